// ### hdl/hsp_pkg.sv
/*
  Shared constants and types of the hub strap and port configuration block.
  Assumes one 100 MHz clock domain and a plain register port with 4-bit byte addresses.
*/
package hsp_pkg;

  // Register port geometry
  localparam int AddrWidth = 4;
  localparam int DataWidth = 16;
  localparam int NumPorts  = 3;

  // Register byte addresses
  localparam logic [AddrWidth-1:0] RegCtrlAddr   = 4'h0;
  localparam logic [AddrWidth-1:0] RegStatusAddr = 4'h4;

  // Control register fields
  localparam int CtrlPowerLsb  = 0;
  localparam int CtrlLedLsb    = 3;
  localparam int CtrlLedSupBit = 6;
  localparam int CtrlGangBit   = 7;
  localparam int CtrlWidth     = 8;
  localparam logic [CtrlWidth-1:0] CtrlReset = 8'h00;

  // Status register fields
  localparam int StatModeLsb   = 0;
  localparam int StatPort3Bit  = 2;
  localparam int StatNonremLsb = 3;
  localparam int StatGangBit   = 5;
  localparam int StatPolBit    = 6;
  localparam int StatVbusBit   = 7;
  localparam int StatValidBit  = 8;
  localparam int StatMaskLsb   = 9;

  // Configuration select encodings, as {select1, select0}
  localparam logic [1:0] CfgStrapMode  = 2'h2;
  localparam logic [1:0] CfgEepromMode = 2'h3;

  // Synchroniser depth and the wait it implies before straps are trusted
  localparam int SyncStages = 2;
  localparam logic [1:0] SyncFillCycles = 2'h2;

  typedef enum logic [1:0] {
    PhFill,
    PhCapture,
    PhRun
  } hsp_phase_t;

endpackage

// ### hdl/hsp_sync.sv
/*
  Two-stage synchroniser for a group of independent pin levels.
  Assumes each bit is a slow level; no bus coherency is implied across bits.
*/
module hsp_sync #(
  parameter int Width = 1
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             arst_n,
  // Levels
  input  wire logic [Width-1:0] pinIn,
  output logic      [Width-1:0] syncOut
);

  typedef struct packed {
    logic [Width-1:0] stage1;
    logic [Width-1:0] stage2;
  } hsp_sync_state_t;

  hsp_sync_state_t st_q;
  hsp_sync_state_t st_d;

  // First stage feeds only the second stage
  always_comb begin
    st_d        = st_q;
    st_d.stage1 = pinIn;
    st_d.stage2 = st_q.stage1;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign syncOut = st_q.stage2;

endmodule

// ### hdl/hsp_pol_out.sv
/*
  Registered polarity stage: drives each output at its active or idle level.
  Assumes active and invert come from logic on the same clock.
*/
module hsp_pol_out #(
  parameter int Width = 3
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             arst_n,
  // Request and polarity
  input  wire logic [Width-1:0] active,
  input  wire logic [Width-1:0] invert,
  // Pin level
  output logic      [Width-1:0] level
);

  typedef struct packed {
    logic [Width-1:0] level;
  } hsp_pol_state_t;

  hsp_pol_state_t st_q;
  hsp_pol_state_t st_d;

  // An inverted output is active low
  always_comb begin
    st_d       = st_q;
    st_d.level = active ^ invert;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign level = st_q.level;

endmodule

// ### hdl/hsp_port_config.sv
/*
  Strap sampling and downstream port configuration of a three-port hub.
  Assumes strap pins are held steady around reset release and that the
  descriptor loader (serial memory or management bus) is software on the
  register port. Strap and LED pins are shared; LEDs stay undriven until
  the straps have been captured.
*/

module hsp_port_config (
  // Clock and reset
  input  wire logic                            clk,
  input  wire logic                            arst_n,
  // Register port
  input  wire logic [hsp_pkg::AddrWidth-1:0]   regAddr,
  input  wire logic [hsp_pkg::DataWidth-1:0]   regWrData,
  input  wire logic                            regWrite,
  input  wire logic                            regRead,
  output logic      [hsp_pkg::DataWidth-1:0]   regRdData,
  // Configuration select and strap pins
  input  wire logic                            configSelect0,
  input  wire logic                            configSelect1,
  input  wire logic                            gangStrap,
  input  wire logic                            powerPolarityStrap,
  input  wire logic                            upstreamPowerSense,
  // Port 3 LED and disable strap (shared pin)
  input  wire logic                            port3GreenLedIn,
  output logic                                 port3GreenLedOut,
  output logic                                 port3GreenLedOe,
  // Port 1 and 2 LEDs and non-removable strap (shared pins)
  input  wire logic [1:0]                      port12GreenLedIn,
  output logic      [1:0]                      port12GreenLedOut,
  output logic      [1:0]                      port12GreenLedOe,
  // Downstream power switch enables
  output logic      [hsp_pkg::NumPorts-1:0]    portPowerEnable
);

  typedef struct packed {
    hsp_pkg::hsp_phase_t                 phase;
    logic [1:0]                          fill;
    logic                                valid;
    logic [1:0]                          cfgMode;
    logic                                port3Dis;
    logic [1:0]                          nonrem;
    logic                                gangStrap;
    logic                                polarity;
    logic [hsp_pkg::CtrlWidth-1:0]       ctrl;
    logic [2:0]                          ledOe;
    logic [hsp_pkg::DataWidth-1:0]       rdData;
  } hsp_state_t;

  hsp_state_t st_q;
  hsp_state_t st_d;

  // Synchronised pins
  logic [7:0] pinSync;
  logic       cfgSel1Sync;
  logic       cfgSel0Sync;
  logic       polSync;
  logic       gangSync;
  logic [1:0] nonremSync;
  logic       port3Sync;
  logic       vbusSync;

  hsp_sync #(
    .Width (8)
  ) u_sync (
    .clk     (clk),
    .arst_n  (arst_n),
    .pinIn   ({configSelect1, configSelect0, powerPolarityStrap, gangStrap,
               port12GreenLedIn, port3GreenLedIn, upstreamPowerSense}),
    .syncOut (pinSync)
  );

  assign {cfgSel1Sync, cfgSel0Sync, polSync, gangSync, nonremSync, port3Sync, vbusSync} = pinSync;

  // Derived configuration
  logic       strapMode;
  logic       ganged;
  logic       ledSupport;
  logic [2:0] nonremMask;
  logic [2:0] powerReq;
  logic [2:0] powerInv;
  logic [2:0] ledReq;
  logic [2:0] ledInv;
  logic [2:0] ledLevel;
  logic [2:0] powerLevel;
  logic [hsp_pkg::DataWidth-1:0] statusWord;

  always_comb begin
    strapMode  = st_q.valid && (st_q.cfgMode == hsp_pkg::CfgStrapMode);
    ledSupport = st_q.ctrl[hsp_pkg::CtrlLedSupBit];
    ganged     = strapMode ? st_q.gangStrap : st_q.ctrl[hsp_pkg::CtrlGangBit];
    // Non-removable ports grow from port 1 upward
    case (st_q.nonrem)
      2'h0:    nonremMask = 3'h0;
      2'h1:    nonremMask = 3'h1;
      2'h2:    nonremMask = 3'h3;
      2'h3:    nonremMask = 3'h7;
      default: nonremMask = 3'h0;
    endcase
    if (!strapMode) begin
      nonremMask = 3'h0;
    end
    powerReq = st_q.ctrl[hsp_pkg::CtrlPowerLsb +: 3];
    if (ganged) begin
      powerReq = {3{powerReq[0]}};
    end
    if (strapMode && st_q.port3Dis) begin
      powerReq[2] = 1'b0;
    end
    if (!st_q.valid) begin
      powerReq = 3'h0;
    end
    // Inverting an active-high polarity gives the active-low drive
    powerInv = st_q.valid ? {3{~st_q.polarity}} : {3{~polSync}};
    ledReq   = st_q.ctrl[hsp_pkg::CtrlLedLsb +: 3];
    if (strapMode) begin
      ledInv = {st_q.port3Dis, st_q.nonrem[1], st_q.nonrem[0]};
    end else begin
      ledInv = 3'h7;
    end
  end

  hsp_pol_out #(
    .Width (3)
  ) u_led_out (
    .clk    (clk),
    .arst_n (arst_n),
    .active (ledReq),
    .invert (ledInv),
    .level  (ledLevel)
  );

  hsp_pol_out #(
    .Width (hsp_pkg::NumPorts)
  ) u_power_out (
    .clk    (clk),
    .arst_n (arst_n),
    .active (powerReq),
    .invert (powerInv),
    .level  (powerLevel)
  );

  always_comb begin
    statusWord = '0;
    statusWord[hsp_pkg::StatModeLsb +: 2]   = st_q.cfgMode;
    statusWord[hsp_pkg::StatPort3Bit]       = strapMode && st_q.port3Dis;
    statusWord[hsp_pkg::StatNonremLsb +: 2] = strapMode ? st_q.nonrem : 2'h0;
    statusWord[hsp_pkg::StatGangBit]        = ganged;
    statusWord[hsp_pkg::StatPolBit]         = st_q.polarity;
    statusWord[hsp_pkg::StatVbusBit]        = vbusSync;
    statusWord[hsp_pkg::StatValidBit]       = st_q.valid;
    statusWord[hsp_pkg::StatMaskLsb +: 3]   = nonremMask;
  end

  // Capture sequence and register port
  always_comb begin
    st_d = st_q;
    case (st_q.phase)
      // Wait until the synchronisers hold pin values sampled after release
      hsp_pkg::PhFill: begin
        st_d.fill = st_q.fill + 2'h1;
        if (st_q.fill == hsp_pkg::SyncFillCycles - 2'h1) begin
          st_d.phase = hsp_pkg::PhCapture;
        end
      end
      hsp_pkg::PhCapture: begin
        st_d.cfgMode   = {cfgSel1Sync, cfgSel0Sync};
        st_d.port3Dis  = port3Sync;
        st_d.nonrem    = nonremSync;
        st_d.gangStrap = gangSync;
        st_d.polarity  = polSync;
        st_d.valid     = 1'b1;
        st_d.phase     = hsp_pkg::PhRun;
      end
      // Straps are never sampled again; only reset leaves this phase
      hsp_pkg::PhRun: begin
        st_d.phase = hsp_pkg::PhRun;
      end
      default: begin
        st_d.phase = hsp_pkg::PhFill;
      end
    endcase
    // Strap mode drives LEDs at once; loader modes only once enabled
    if (strapMode) begin
      st_d.ledOe = 3'h7;
    end else if (st_q.valid && ledSupport) begin
      st_d.ledOe = 3'h7;
    end else begin
      st_d.ledOe = 3'h0;
    end
    if (regWrite && (regAddr == hsp_pkg::RegCtrlAddr)) begin
      st_d.ctrl = regWrData[hsp_pkg::CtrlWidth-1:0];
    end
    st_d.rdData = '0;
    if (regRead) begin
      case (regAddr)
        hsp_pkg::RegCtrlAddr:   st_d.rdData = {{(hsp_pkg::DataWidth-hsp_pkg::CtrlWidth){1'b0}},
                                               st_q.ctrl};
        hsp_pkg::RegStatusAddr: st_d.rdData = statusWord;
        default:                st_d.rdData = '0;
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q       <= '0;
      st_q.phase <= hsp_pkg::PhFill;
      st_q.ctrl  <= hsp_pkg::CtrlReset;
    end else begin
      st_q <= st_d;
    end
  end

  assign regRdData         = st_q.rdData;
  assign port3GreenLedOut  = ledLevel[2];
  assign port12GreenLedOut = ledLevel[1:0];
  assign port3GreenLedOe   = st_q.ledOe[2];
  assign port12GreenLedOe  = st_q.ledOe[1:0];
  // The pin sets the idle level directly until it is latched, so no port
  // is powered by accident during reset
  assign portPowerEnable   = st_q.valid ? powerLevel : {3{~powerPolarityStrap}};

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  a_port3_off: assert property (st_q.valid && $past(st_q.valid) && strapMode
    && st_q.port3Dis |-> portPowerEnable[2] == ~st_q.polarity)
    else $error("disabled port 3 powered");

  a_port3_led: assert property (strapMode && $past(strapMode) && !$past(regWrite)
    |-> port3GreenLedOut == (st_q.ctrl[hsp_pkg::CtrlLedLsb + 2] ^ st_q.port3Dis))
    else $error("port 3 led polarity wrong");

  a_nonrem_mask: assert property (strapMode |->
    nonremMask == ((st_q.nonrem == 2'h3) ? 3'h7 : (st_q.nonrem == 2'h2) ? 3'h3 :
                   (st_q.nonrem == 2'h1) ? 3'h1 : 3'h0))
    else $error("non-removable mask wrong");

  a_led12_pol: assert property (strapMode && $past(strapMode) && !$past(regWrite)
    |-> port12GreenLedOut == (st_q.ctrl[hsp_pkg::CtrlLedLsb +: 2] ^ st_q.nonrem))
    else $error("port 1-2 led polarity wrong");

  a_all_fixed: assert property (strapMode && st_q.nonrem == 2'h3
    |-> statusWord[hsp_pkg::StatMaskLsb +: 3] == 3'h7)
    else $error("all-fixed setting lost");

  a_gang_follow: assert property (ganged && st_q.valid |-> powerReq[1] == powerReq[0])
    else $error("ganged ports differ");

  a_loader_led: assert property (st_q.valid && !strapMode && ledSupport
    |=> port3GreenLedOe && port12GreenLedOe == 2'h3)
    else $error("loader led not driven");

  a_power_level: assert property (st_q.valid && $past(st_q.valid)
    |-> portPowerEnable == ($past(powerReq) ^ {3{~st_q.polarity}}))
    else $error("power enable level wrong");

  a_vbus_read: assert property (regRead && regAddr == hsp_pkg::RegStatusAddr
    |=> regRdData[hsp_pkg::StatVbusBit] == $past(vbusSync))
    else $error("upstream power status wrong");

  a_reset_pol: assert property (!st_q.valid
    |-> portPowerEnable == {3{~powerPolarityStrap}})
    else $error("pre-capture power level wrong");

  a_mode_catch: assert property (st_q.phase == hsp_pkg::PhCapture
    |=> st_q.valid && st_q.cfgMode == $past({cfgSel1Sync, cfgSel0Sync}))
    else $error("configuration mode not latched");

  a_straps_hold: assert property (st_q.valid |=> st_q.valid && $stable(st_q.cfgMode)
    && $stable(st_q.port3Dis) && $stable(st_q.nonrem) && $stable(st_q.gangStrap)
    && $stable(st_q.polarity))
    else $error("latched strap changed");

  c_strap_mode: cover property ($rose(st_q.valid) && strapMode);
  c_port3_dis:  cover property (strapMode && st_q.port3Dis && st_q.ctrl[2]);
  c_ganged:     cover property (strapMode && st_q.gangStrap && powerReq == 3'h7);
  c_loader_led: cover property (!strapMode && st_q.valid && ledSupport);

endmodule

// ### sim/hsp_strap_partner.sv
/*
  Far-side model of the shared LED and strap pins: a strap resistor and an LED on each.
  Assumes the bench sets the resistor levels before reset is released.
*/
module hsp_strap_partner (
  // Strap resistor levels
  input  wire logic       port3Strap,
  input  wire logic [1:0] nonremStrap,
  // Hub side of the shared pins
  input  wire logic       port3Out,
  input  wire logic       port3Oe,
  input  wire logic [1:0] port12Out,
  input  wire logic [1:0] port12Oe,
  // Resolved pin levels
  output logic            port3Pin,
  output logic      [1:0] port12Pin
);
  timeunit 1ns;
  timeprecision 1ps;
  // A released pin is pulled to its strap level, so the hub reads the strap
  assign port3Pin = port3Oe ? port3Out : port3Strap;
  always_comb begin
    for (int k = 0; k < 2; k++) begin
      port12Pin[k] = port12Oe[k] ? port12Out[k] : nonremStrap[k];
    end
  end
endmodule

// ### sim/hub_strap_port_config_tb.sv
/*
  Self-checking bench of the hub strap and port configuration block.
  Assumes the strap partner model resolves the shared LED pins.
*/
module hub_strap_port_config_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, arst_n, regWrite, regRead, cfgSel0, cfgSel1, gangStrap, polStrap, vbus;
  logic        p3Strap, p3Pin, p3Out, p3Oe;
  logic [1:0]  nrStrap, p12Pin, p12Out, p12Oe;
  logic [2:0]  pwr;
  logic [3:0]  regAddr;
  logic [15:0] regWrData, regRdData, d, stat;
  int          n_fail, checked;

  hsp_port_config dut (.clk(clk), .arst_n(arst_n), .regAddr(regAddr), .regWrData(regWrData),
    .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData), .configSelect0(cfgSel0),
    .configSelect1(cfgSel1), .gangStrap(gangStrap), .powerPolarityStrap(polStrap),
    .upstreamPowerSense(vbus), .port3GreenLedIn(p3Pin), .port3GreenLedOut(p3Out),
    .port3GreenLedOe(p3Oe), .port12GreenLedIn(p12Pin), .port12GreenLedOut(p12Out),
    .port12GreenLedOe(p12Oe), .portPowerEnable(pwr));
  hsp_strap_partner partner (.port3Strap(p3Strap), .nonremStrap(nrStrap), .port3Out(p3Out),
    .port3Oe(p3Oe), .port12Out(p12Out), .port12Oe(p12Oe), .port3Pin(p3Pin),
    .port12Pin(p12Pin));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic test_done();
    $display("checked=%0d n_fail=%0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic cmp_reg(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmp_pin(input logic [2:0] got, input logic [2:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Pins show a write one edge after the edge that samples the strobe
  task automatic reg_write(input logic [3:0] a, input logic [15:0] v);
    @(posedge clk);
    regAddr <= a;
    regWrData <= v;
    regWrite <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
    @(posedge clk);
    #1;
  endtask

  task automatic reg_read(input logic [3:0] a, output logic [15:0] v);
    @(posedge clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk);
    regRead <= 1'b0;
    #1 v = regRdData;
  endtask

  task automatic do_reset(input logic s1, s0, dis, input logic [1:0] nr, input logic g, p, vb);
    @(posedge clk);
    arst_n <= 1'b0;
    cfgSel1 <= s1;
    cfgSel0 <= s0;
    p3Strap <= dis;
    nrStrap <= nr;
    gangStrap <= g;
    polStrap <= p;
    vbus <= vb;
    #1 cmp_pin(pwr, {3{~p}});
    @(posedge clk);
    polStrap <= ~p;
    #1 cmp_pin(pwr, {3{p}});
    @(posedge clk);
    polStrap <= p;
    @(posedge clk);
    arst_n <= 1'b1;
    repeat (5) @(posedge clk);
    #1;
  endtask

  // Gang follows request bit 0; a strap-disabled port 3 stays off
  function automatic logic [2:0] pwr_exp(logic [2:0] req, logic g, dis, p);
    logic [2:0] r;
    r = g ? {3{req[0]}} : req;
    if (dis) r[2] = 1'b0;
    return r ^ {3{~p}};
  endfunction

  initial begin
    #100_000;
    n_fail++;
    test_done();
  end

  initial begin
    logic [3:0] i;
    logic [2:0] mask;
    logic       p;
    {arst_n, regWrite, regRead, cfgSel0, cfgSel1, gangStrap, polStrap, vbus} = 8'h00;
    {p3Strap, nrStrap, regAddr, regWrData} = 23'h0;
    n_fail = 0;
    checked = 0;
    for (int k = 0; k < 16; k++) begin
      i = k[3:0];
      p = i[1] ^ i[2];
      do_reset(1'b1, 1'b0, i[2], i[1:0], i[3], p, i[0]);
      mask = (i[1:0] == 2'h0) ? 3'h0 : (i[1:0] == 2'h1) ? 3'h1 : (i[1:0] == 2'h2) ? 3'h3 : 3'h7;
      stat = {4'h0, mask, 1'b1, i[0], p, i[3], i[1:0], i[2], 2'h2};
      reg_read(4'h4, d);
      cmp_reg(d, stat);
      cmp_pin({p3Oe, p12Oe}, 3'h7);
      cmp_pin(pwr, {3{~p}});
      reg_write(4'h0, 16'h003f);
      cmp_pin(pwr, pwr_exp(3'h7, i[3], i[2], p));
      cmp_pin({p3Out, p12Out}, 3'h7 ^ {i[2], i[1:0]});
      reg_read(4'h0, d);
      cmp_reg(d, 16'h003f);
      reg_write(4'h0, 16'h0006);
      cmp_pin(pwr, pwr_exp(3'h6, i[3], i[2], p));
      cmp_pin({p3Out, p12Out}, {i[2], i[1:0]});
      // Late strap changes must not leak into the captured configuration
      @(posedge clk);
      {p3Strap, nrStrap, gangStrap, polStrap, cfgSel0, vbus} <=
        {~i[2], ~i[1:0], ~i[3], ~p, 1'b1, ~i[0]};
      repeat (4) @(posedge clk);
      reg_write(4'h4, 16'hffff);
      reg_read(4'h8, d);
      cmp_reg(d, 16'h0000);
      stat[7] = ~i[0];
      reg_read(4'h4, d);
      cmp_reg(d, stat);
      cmp_pin(pwr, pwr_exp(3'h6, i[3], i[2], p));
    end
    for (int m = 0; m < 2; m++) begin
      do_reset(m[0], 1'b1, 1'b1, 2'h3, 1'b0, 1'b1, 1'b1);
      reg_read(4'h4, d);
      cmp_reg(d & 16'h01df, {7'h0, 7'h70, m[0], 1'b1});
      cmp_pin({p3Oe, p12Oe}, 3'h0);
      reg_write(4'h0, 16'h004d);
      cmp_pin({p3Oe, p12Oe}, 3'h7);
      cmp_pin({p3Out, p12Out}, 3'h6);
      cmp_pin(pwr, 3'h5);
      reg_write(4'h0, 16'h0081);
      cmp_pin(pwr, 3'h7);
    end
    test_done();
  end
endmodule
